// ==== rtl/stp_params.svh ====
`ifndef STP_PARAMS_SVH
`define STP_PARAMS_SVH

`define STP_ADDR_W      12
`define STP_DATA_W      32
`define STP_PS_W        10
`define STP_SEL_W       3
`define STP_CNT_W       16

// register indices; byte address is four times the index
`define STP_IDX_GTC     10'h043
`define STP_IDX_SEL0    10'h044
`define STP_IDX_SEL1    10'h045
`define STP_IDX_STAT    10'h046
`define STP_IDX_CNT0    10'h047
`define STP_IDX_CNT1    10'h048

`define STP_GTC_HOLD    7
`define STP_GTC_ASYNC   1
`define STP_GTC_SYNC    0
`define STP_GTC_RST     8'h00
`define STP_SEL_RST     3'h0

`define STP_MASK_DIV8    10'h007
`define STP_MASK_DIV64   10'h03f
`define STP_MASK_DIV256  10'h0ff
`define STP_MASK_DIV1024 10'h3ff

`endif

// ==== rtl/stp_pkg.sv ====
package stp_pkg;
  typedef logic [2:0]  stp_sel_t;
  typedef logic [1:0]  stp_pair_t;
  typedef logic [11:0] stp_addr_t;
  typedef logic [31:0] stp_word_t;
  // order matches the select code 0..7
  typedef enum logic [2:0] {
    SRC_STOP,
    SRC_SYSCLK,
    SRC_DIV8,
    SRC_DIV64,
    SRC_DIV256,
    SRC_DIV1024,
    SRC_EXT_FALL,
    SRC_EXT_RISE
  } stp_src_t;
endpackage

// ==== rtl/stp_edge_if.sv ====
interface stp_edge_if;
  logic rise;
  logic fall;
  logic level;
  modport src (output rise, output fall, output level);
  modport dst (input rise, input fall, input level);
endinterface

// ==== rtl/stp_pin_sync.sv ====
module stp_pin_sync (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // raw pin
  input  wire logic external_count_pin,
  // edge events
  stp_edge_if.src   edge_o
);
  import stp_pkg::*;

  logic front_lat;
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  // half-cycle front end adds half a clock to the pin latency
  always_latch begin
    if (pclk) begin
      front_lat <= external_count_pin;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= front_lat;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // compare only stages past the first flop to keep metastability out
  assign edge_o.rise  = s2_ff & ~s3_ff;
  assign edge_o.fall  = ~s2_ff & s3_ff;
  assign edge_o.level = s2_ff;
endmodule

// ==== rtl/stp_top.sv ====
`include "stp_params.svh"

module stp_top #(
  parameter int PS_W  = `STP_PS_W,
  parameter int CNT_W = `STP_CNT_W
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire stp_pkg::stp_addr_t paddr,
  input  wire stp_pkg::stp_word_t pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output stp_pkg::stp_word_t     prdata,
  output logic                   pslverr,
  // external count pins, index = timer
  input  wire stp_pkg::stp_pair_t external_count_pin,
  // ticks to the two timers
  output stp_pkg::stp_pair_t     timer_tick,
  // control levels to neighbouring timer logic
  output logic                   sync_hold_mode,
  output logic                   sync_prescaler_reset,
  output logic                   async_prescaler_reset
);
  import stp_pkg::*;

  // ---------------------------------------------------------------
  // address, tap and tick-source decode helpers
  // ---------------------------------------------------------------
  function automatic logic reg_hit(input stp_addr_t a, input logic [9:0] idx);
    reg_hit = (a == {idx, 2'b00});
  endfunction

  function automatic logic tap_hit(input logic [PS_W-1:0] c,
                                   input logic [PS_W-1:0] m);
    tap_hit = ((c & m) == m);
  endfunction

  function automatic logic pick_tick(input stp_src_t src,
                                     input logic [3:0] taps,
                                     input logic       rise,
                                     input logic       fall);
    case (src)
      SRC_STOP:     pick_tick = 1'b0;
      SRC_SYSCLK:   pick_tick = 1'b1;
      SRC_DIV8:     pick_tick = taps[0];
      SRC_DIV64:    pick_tick = taps[1];
      SRC_DIV256:   pick_tick = taps[2];
      SRC_DIV1024:  pick_tick = taps[3];
      SRC_EXT_FALL: pick_tick = fall;
      SRC_EXT_RISE: pick_tick = rise;
      default:      pick_tick = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // apb phases
  // ---------------------------------------------------------------
  logic setup_ph;
  logic access_ph;
  logic mapped;
  logic wr_low;
  logic wr_gtc;
  logic wr_sel0;
  logic wr_sel1;
  logic wr_cnt0;
  logic wr_cnt1;

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;

  always_comb begin
    mapped = reg_hit(paddr, `STP_IDX_GTC)
           | reg_hit(paddr, `STP_IDX_SEL0)
           | reg_hit(paddr, `STP_IDX_SEL1)
           | reg_hit(paddr, `STP_IDX_STAT)
           | reg_hit(paddr, `STP_IDX_CNT0)
           | reg_hit(paddr, `STP_IDX_CNT1);
  end

  // every register is answered in one access cycle
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~mapped;

  // byte lane 0 carries every writable field
  assign wr_low  = access_ph & pwrite & pstrb[0];
  assign wr_gtc  = wr_low & reg_hit(paddr, `STP_IDX_GTC);
  assign wr_sel0 = wr_low & reg_hit(paddr, `STP_IDX_SEL0);
  assign wr_sel1 = wr_low & reg_hit(paddr, `STP_IDX_SEL1);
  // counter clear accepts any lane
  assign wr_cnt0 = access_ph & pwrite & reg_hit(paddr, `STP_IDX_CNT0);
  assign wr_cnt1 = access_ph & pwrite & reg_hit(paddr, `STP_IDX_CNT1);

  // ---------------------------------------------------------------
  // general timer control
  // ---------------------------------------------------------------
  logic hold_ff;
  logic psr_sync_ff;
  logic psr_async_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ff <= 1'b0;
    end else if (wr_gtc) begin
      hold_ff <= pwdata[`STP_GTC_HOLD];
    end
  end

  // a reset bit lasts one cycle after its write unless hold is on;
  // writing hold to zero also writes the reset bits, so they clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psr_sync_ff <= 1'b0;
    end else if (wr_gtc) begin
      psr_sync_ff <= pwdata[`STP_GTC_SYNC] & 1'b1;
      if (!pwdata[`STP_GTC_HOLD] && hold_ff) begin
        psr_sync_ff <= 1'b0;
      end
    end else if (!hold_ff) begin
      psr_sync_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psr_async_ff <= 1'b0;
    end else if (wr_gtc) begin
      psr_async_ff <= pwdata[`STP_GTC_ASYNC];
      if (!pwdata[`STP_GTC_HOLD] && hold_ff) begin
        psr_async_ff <= 1'b0;
      end
    end else if (!hold_ff) begin
      psr_async_ff <= 1'b0;
    end
  end

  assign sync_hold_mode        = hold_ff;
  assign sync_prescaler_reset  = psr_sync_ff;
  assign async_prescaler_reset = psr_async_ff;

  // ---------------------------------------------------------------
  // shared prescaler
  // ---------------------------------------------------------------
  logic [PS_W-1:0] ps_cnt_ff;
  logic [PS_W-1:0] nxt_ps_cnt;
  logic [3:0]      taps;

  always_comb begin
    nxt_ps_cnt = ps_cnt_ff + {{(PS_W-1){1'b0}}, 1'b1};
    if (psr_sync_ff) begin
      nxt_ps_cnt = '0;
    end
  end

  // never gated by either select field, so both timers see one phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_cnt_ff <= '0;
    end else begin
      ps_cnt_ff <= nxt_ps_cnt;
    end
  end

  // taps fire on the last count of each period; a held reset
  // suppresses them so the attached timers stay halted
  always_comb begin
    taps[0] = tap_hit(ps_cnt_ff, `STP_MASK_DIV8)    & ~psr_sync_ff;
    taps[1] = tap_hit(ps_cnt_ff, `STP_MASK_DIV64)   & ~psr_sync_ff;
    taps[2] = tap_hit(ps_cnt_ff, `STP_MASK_DIV256)  & ~psr_sync_ff;
    taps[3] = tap_hit(ps_cnt_ff, `STP_MASK_DIV1024) & ~psr_sync_ff;
  end

  // ---------------------------------------------------------------
  // per-timer tick source select
  // ---------------------------------------------------------------
  stp_sel_t sel0_ff;
  stp_sel_t sel1_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel0_ff <= `STP_SEL_RST;
    end else if (wr_sel0) begin
      sel0_ff <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel1_ff <= `STP_SEL_RST;
    end else if (wr_sel1) begin
      sel1_ff <= pwdata[2:0];
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers and tick mux
  // ---------------------------------------------------------------
  stp_edge_if pin_edge0 ();
  stp_edge_if pin_edge1 ();

  stp_pin_sync u_sync0 (
    .pclk               (pclk),
    .presetn            (presetn),
    .external_count_pin (external_count_pin[0]),
    .edge_o             (pin_edge0.src)
  );

  stp_pin_sync u_sync1 (
    .pclk               (pclk),
    .presetn            (presetn),
    .external_count_pin (external_count_pin[1]),
    .edge_o             (pin_edge1.src)
  );

  // edge events run even while another source is chosen; a source
  // switch while the pin moves may give one spurious tick
  always_comb begin
    timer_tick[0] = pick_tick(stp_src_t'(sel0_ff), taps,
                              pin_edge0.rise, pin_edge0.fall);
    timer_tick[1] = pick_tick(stp_src_t'(sel1_ff), taps,
                              pin_edge1.rise, pin_edge1.fall);
  end

  // ---------------------------------------------------------------
  // tick counters for observation
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] tcnt0_ff;
  logic [CNT_W-1:0] tcnt1_ff;

  // a tick in the clearing cycle is kept: count restarts at one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcnt0_ff <= '0;
    end else if (wr_cnt0) begin
      tcnt0_ff <= {{(CNT_W-1){1'b0}}, timer_tick[0]};
    end else if (timer_tick[0]) begin
      tcnt0_ff <= tcnt0_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcnt1_ff <= '0;
    end else if (wr_cnt1) begin
      tcnt1_ff <= {{(CNT_W-1){1'b0}}, timer_tick[1]};
    end else if (timer_tick[1]) begin
      tcnt1_ff <= tcnt1_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // ---------------------------------------------------------------
  // read path, captured in the setup cycle
  // ---------------------------------------------------------------
  stp_word_t rd_val;
  stp_word_t prdata_ff;

  always_comb begin
    rd_val = '0;
    if (reg_hit(paddr, `STP_IDX_GTC)) begin
      rd_val[`STP_GTC_HOLD]  = hold_ff;
      rd_val[`STP_GTC_ASYNC] = psr_async_ff;
      rd_val[`STP_GTC_SYNC]  = psr_sync_ff;
    end else if (reg_hit(paddr, `STP_IDX_SEL0)) begin
      rd_val[2:0] = sel0_ff;
    end else if (reg_hit(paddr, `STP_IDX_SEL1)) begin
      rd_val[2:0] = sel1_ff;
    end else if (reg_hit(paddr, `STP_IDX_STAT)) begin
      rd_val[PS_W-1:0] = ps_cnt_ff;
      rd_val[16]       = pin_edge0.level;
      rd_val[17]       = pin_edge1.level;
    end else if (reg_hit(paddr, `STP_IDX_CNT0)) begin
      rd_val[CNT_W-1:0] = tcnt0_ff;
    end else if (reg_hit(paddr, `STP_IDX_CNT1)) begin
      rd_val[CNT_W-1:0] = tcnt1_ff;
    end
  end

  // status values are a snapshot from the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
    end else if (setup_ph && !pwrite) begin
      prdata_ff <= rd_val;
    end
  end

  assign prdata = prdata_ff;
endmodule

// ==== tb/stp_top_assertions.sv ====
module stp_top_assertions (
  // clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // apb
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire stp_pkg::stp_addr_t paddr,
  input wire stp_pkg::stp_word_t pwdata,
  input wire logic [3:0]         pstrb,
  input wire logic               pready,
  input wire stp_pkg::stp_word_t prdata,
  input wire logic               pslverr,
  // pins, ticks, control levels
  input wire stp_pkg::stp_pair_t external_count_pin,
  input wire stp_pkg::stp_pair_t timer_tick,
  input wire logic               sync_hold_mode,
  input wire logic               sync_prescaler_reset,
  input wire logic               async_prescaler_reset
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] sel0_ff;
  logic [2:0] sel1_ff;
  logic [9:0] ps_ff;
  wire wr = psel && penable && pwrite && pstrb[0];
  wire gtc_wr = wr && paddr == 12'h10c;
  // shadow of the select registers, taken from the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel0_ff <= 3'h0;
      sel1_ff <= 3'h0;
    end else begin
      if (wr && paddr == 12'h110) sel0_ff <= pwdata[2:0];
      if (wr && paddr == 12'h114) sel1_ff <= pwdata[2:0];
    end
  end
  // reference divider: zero the cycle after the reset level is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ps_ff <= 10'h000;
    else ps_ff <= sync_prescaler_reset ? 10'h000 : ps_ff + 10'h001;
  end
  function automatic logic tap(input logic [2:0] s, input logic [9:0] p, input logic r);
    case (s)
      3'h1: return 1'b1;
      3'h2: return &p[2:0] & ~r;
      3'h3: return &p[5:0] & ~r;
      3'h4: return &p[7:0] & ~r;
      3'h5: return &p & ~r;
      default: return 1'b0;
    endcase
  endfunction
  chk_tick0_src:
    assert property (sel0_ff < 3'h6 |-> timer_tick[0] == tap(sel0_ff, ps_ff, sync_prescaler_reset))
      else $error("timer 0 tick wrong for its source");
  chk_tick1_src:
    assert property (sel1_ff < 3'h6 |-> timer_tick[1] == tap(sel1_ff, ps_ff, sync_prescaler_reset))
      else $error("timer 1 tick wrong for its source");
  chk_ext_rise:
    assert property (sel0_ff == 3'h7 && $rose(external_count_pin[0]) |-> ##[2:3] timer_tick[0])
      else $error("rising pin edge gave no tick in time");
  chk_ext_fall:
    assert property (sel1_ff == 3'h6 && $fell(external_count_pin[1]) |-> ##[2:3] timer_tick[1])
      else $error("falling pin edge gave no tick in time");
  chk_ext_single:
    assert property (sel0_ff == 3'h7 && timer_tick[0] |=> !timer_tick[0])
      else $error("pin tick longer than one cycle");
  chk_sync_pulse:
    assert property (gtc_wr && pwdata[0] && !pwdata[7] && !sync_hold_mode
      |=> sync_prescaler_reset ##1 !sync_prescaler_reset) else $error("reset bit not a pulse");
  chk_hold_keeps:
    assert property (sync_hold_mode && !gtc_wr
      |=> $stable(sync_prescaler_reset) && $stable(async_prescaler_reset))
      else $error("reset bits moved under hold");
  chk_hold_clear:
    assert property (gtc_wr && sync_hold_mode && !pwdata[7]
      |=> !sync_prescaler_reset && !async_prescaler_reset) else $error("hold exit left reset set");
  cover property (sel0_ff == 3'h2 && timer_tick[0]);
  cover property (gtc_wr && sync_hold_mode && !pwdata[7]);
  cover property (sel1_ff == 3'h6 && timer_tick[1]);
endmodule

bind stp_top stp_top_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .pready, .prdata, .pslverr, .external_count_pin, .timer_tick,
  .sync_hold_mode, .sync_prescaler_reset, .async_prescaler_reset);

// ==== tb/stp_timer_model.sv ====
module stp_timer_model (
  // clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // ticks from the prescaler
  input wire stp_pkg::stp_pair_t timer_tick,
  // ticks taken by each timer
  output logic [15:0]            cnt0_ff,
  output logic [15:0]            cnt1_ff
);
  // each timer counts one step per tick; a stopped source simply leaves it still
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt0_ff <= 16'h0000;
    else if (timer_tick[0]) cnt0_ff <= cnt0_ff + 16'h0001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt1_ff <= 16'h0000;
    else if (timer_tick[1]) cnt1_ff <= cnt1_ff + 16'h0001;
  end
endmodule

// ==== tb/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import stp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sh, sr, ar, err;
  logic [3:0] pstrb;
  stp_addr_t paddr;
  stp_word_t pwdata, prdata, rd;
  stp_pair_t pin, tick;
  logic [15:0] c0, c1, s0, s1;
  int fails, tests_run, cyc, n;
  int per[6] = '{0, 2048, 256, 32, 8, 2};
  stp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .external_count_pin(pin), .timer_tick(tick),
    .sync_hold_mode(sh), .sync_prescaler_reset(sr), .async_prescaler_reset(ar));
  stp_timer_model u_tmr (.pclk(pclk), .presetn(presetn), .timer_tick(tick),
    .cnt0_ff(c0), .cnt1_ff(c1));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // whole run is about 12.6k cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      final_report();
    end
  end
  task final_report;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(string nm, stp_word_t e, stp_word_t s);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task apb(logic w, stp_addr_t a, stp_word_t d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // skip one edge so the old select cannot leak into the count
  task window(int len);
    @(posedge pclk);
    s0 = c0; s1 = c1;
    repeat (len) @(posedge pclk);
    s0 = c0 - s0; s1 = c1 - s1;
  endtask
  task first_tick;
    n = 0;
    do begin @(posedge pclk); n++; end while (tick[0] !== 1'b1 && n < 2000);
    chk("both_ticks", 32'h3, {30'h0, tick});
  endtask
  task t_regs;
    apb(0, 12'h10c, 0); chk("gtc_reset", 0, rd);
    apb(1, 12'h10c, 32'h7c); apb(0, 12'h10c, 0); chk("gtc_reserved", 0, rd);
    apb(0, 12'h200, 0); chk("unmapped_err", 1, {31'h0, err});
    chk("unmapped_data", 0, rd);
    chk("ready_level", 1, {31'h0, pready});
    $display("regs test done");
  endtask
  task t_taps;
    for (int c = 0; c < 6; c++) begin
      apb(1, 12'h110, 32'(c)); apb(1, 12'h114, 32'(5 - c));
      window(2048);
      chk("tap0_count", 32'(per[c]), 32'(s0));
      chk("tap1_count", 32'(per[5 - c]), 32'(s1));
    end
    $display("taps test done");
  endtask
  task t_psr;
    apb(1, 12'h110, 2); apb(1, 12'h114, 2); apb(1, 12'h10c, 1);
    first_tick; chk("first_tick", 9, 32'(n));
    apb(0, 12'h10c, 0); chk("psr_selfclear", 0, rd);
    $display("prescaler reset test done");
  endtask
  task t_hold;
    apb(1, 12'h10c, 32'h83); window(100);
    chk("held0", 0, 32'(s0)); chk("held1", 0, 32'(s1));
    chk("async_held", 1, {31'h0, ar});
    chk("sync_held", 1, {31'h0, sr});
    chk("hold_level", 1, {31'h0, sh});
    apb(0, 12'h10c, 0); chk("hold_read", 32'h83, rd);
    apb(1, 12'h10c, 0); first_tick; chk("resume_tick", 8, 32'(n));
    chk("sync_released", 0, {31'h0, sr});
    chk("async_released", 0, {31'h0, ar});
    chk("hold_off", 0, {31'h0, sh});
    apb(0, 12'h10c, 0); chk("hold_cleared", 0, rd);
    $display("hold test done");
  endtask
  task t_ext;
    apb(1, 12'h110, 7); apb(1, 12'h114, 6);
    apb(1, 12'h11c, 0);
    s0 = c0; s1 = c1;
    repeat (5) begin
      pin <= 2'b11; repeat (4) @(posedge pclk);
      pin <= 2'b00; repeat (4) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
    chk("ext_rise", 5, 32'(c0 - s0));
    chk("ext_fall", 5, 32'(c1 - s1));
    apb(0, 12'h11c, 0); chk("cnt0_reg", 5, rd);
    apb(1, 12'h110, 0); apb(1, 12'h114, 0);
    $display("external pin test done");
  endtask
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    pstrb = 4'hf; pin = 2'b00; presetn = 1'b0; cyc = 0; fails = 0; tests_run = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_taps;
    t_psr;
    t_hold;
    t_ext;
    final_report;
  end
endmodule
